// file: logic/temp_alarm_limit_registers.sv
// Temperature trip-point registers and alarm comparator
`timescale 1ns/10ps
// Summary of operation
// - Upper trip point register at pointer 02h, signed, 0.25 degC steps.
// - Upper alarm sets above upper limit, clears at limit minus hysteresis.
// - Window lock set makes the upper register ignore writes.
// - Bits 15:13 and 1:0 read zero; bits 11:2 hold the magnitude.
// - Bit 12 is the writable sign bit of the threshold.
// - Lower trip point register at pointer 03h, signed, 0.25 degC steps.
// - Lower alarm sets below limit minus hysteresis, clears at or above limit.
// - Window lock set makes the lower register ignore writes.
// - Critical trip point register at pointer 04h, signed.
// - Critical alarm sets above limit, holds until limit minus hysteresis.
// - Critical lock set makes the critical register read-only.
// - Two-bit select gives hysteresis off, 1.5, 3.0 or 6.0 degC.
// - Alarm output stays off unless output enable is set.
// - Critical-only mode lets just the critical alarm drive the output.
// - Lock bits stick once set; only reset clears them.
module temp_alarm_limit_registers (
	input  wire logic        sys_clk,           // Core clock, 250 MHz
	input  wire logic        rst,               // Synchronous reset
	input  wire logic        link_clk,          // Serial link clock
	input  wire logic        link_req,          // Register request pulse
	input  wire logic        link_write,        // 1 write, 0 read
	input  wire logic [7:0]  link_ptr,          // Register pointer
	input  wire logic [15:0] link_wdata,        // Write data
	output logic             link_busy,         // Request outstanding
	output logic             link_done,         // Completion pulse
	output logic [15:0]      link_rdata,        // Read data
	input  wire logic [11:0] temp_meas,         // Temperature bits 12:1
	input  wire logic        window_lock_bit,   // Window lock request
	input  wire logic        critical_lock_bit, // Critical lock request
	input  wire logic [1:0]  hysteresis_select, // Hysteresis code
	input  wire logic        alarm_output_enable, // Alarm output enable
	input  wire logic        critical_only,     // Critical-only mode
	output logic             alarm_out,         // Alarm pin, active high
	output logic             upper_alarm,       // Above upper limit
	output logic             lower_alarm,       // Below lower limit
	output logic             crit_alarm,        // Above critical limit
	output logic             window_locked,     // Sticky window lock
	output logic             critical_locked    // Sticky critical lock
);

	// ==========================================================
	// Arithmetic helpers
	// Threshold bits 12:2 widened to the 0.125 degC grid, signed
	function automatic logic signed [13:0] thr_ext(
		input logic [15:0] r);
		thr_ext = {{2{r[temp_alarm_pkg::THR_MSB]}},
			r[temp_alarm_pkg::THR_MSB:temp_alarm_pkg::THR_LSB],
			1'b0};
	endfunction : thr_ext

	// Hysteresis in 0.125 degC steps
	function automatic logic signed [13:0] hyst_steps(
		input logic [1:0] sel);
		if (sel == temp_alarm_pkg::HSEL_OFF) begin
			hyst_steps = temp_alarm_pkg::HYST_OFF;
		end else if (sel == temp_alarm_pkg::HSEL_1P5) begin
			hyst_steps = temp_alarm_pkg::HYST_1P5;
		end else if (sel == temp_alarm_pkg::HSEL_3P0) begin
			hyst_steps = temp_alarm_pkg::HYST_3P0;
		end else begin
			hyst_steps = temp_alarm_pkg::HYST_6P0;
		end
	endfunction : hyst_steps

	// ==========================================================
	// Link port and crossing
	reg_xfer_if xfer ();

	link_port u_link (
		.link_clk   (link_clk),
		.rst        (rst),
		.link_req   (link_req),
		.link_write (link_write),
		.link_ptr   (link_ptr),
		.link_wdata (link_wdata),
		.link_busy  (link_busy),
		.link_done  (link_done),
		.link_rdata (link_rdata),
		.xfer       (xfer)
	);

	logic        req_s1_r, req_s2_r, req_s3_r;
	logic        ack_tgl_r;
	logic [15:0] rdata_r;
	logic        req_evt;
	logic        wr_evt;
	logic        rd_evt_r;

	// Request toggle synchroniser; stage one feeds stage two only
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			req_s1_r <= temp_alarm_pkg::FLAG_RST;
			req_s2_r <= temp_alarm_pkg::FLAG_RST;
			req_s3_r <= temp_alarm_pkg::FLAG_RST;
		end else begin
			req_s1_r <= xfer.req_tgl;
			req_s2_r <= req_s1_r;
			req_s3_r <= req_s2_r;
		end
	end
	assign req_evt = req_s2_r ^ req_s3_r;
	assign wr_evt  = req_evt && xfer.write;

	// ==========================================================
	// Sticky lock bits
	logic win_lock_r, crit_lock_r;

	// Once seen high the locks hold until reset
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			win_lock_r  <= temp_alarm_pkg::FLAG_RST;
			crit_lock_r <= temp_alarm_pkg::FLAG_RST;
		end else begin
			win_lock_r  <= win_lock_r | window_lock_bit;
			crit_lock_r <= crit_lock_r | critical_lock_bit;
		end
	end

	// ==========================================================
	// Trip-point registers
	logic [15:0] upper_r, lower_r, crit_r;
	logic        sel_upper, sel_lower, sel_crit;

	assign sel_upper = (xfer.ptr == temp_alarm_pkg::PTR_UPPER);
	assign sel_lower = (xfer.ptr == temp_alarm_pkg::PTR_LOWER);
	assign sel_crit  = (xfer.ptr == temp_alarm_pkg::PTR_CRIT);

	// Upper limit; locked writes are simply dropped
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			upper_r <= temp_alarm_pkg::TRIP_RST;
		end else if (wr_evt && sel_upper && !win_lock_r) begin
			upper_r <= xfer.wdata & temp_alarm_pkg::TRIP_MASK;
		end
	end

	// Lower limit
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			lower_r <= temp_alarm_pkg::TRIP_RST;
		end else if (wr_evt && sel_lower && !win_lock_r) begin
			lower_r <= xfer.wdata & temp_alarm_pkg::TRIP_MASK;
		end
	end

	// Critical limit, guarded by its own lock only
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			crit_r <= temp_alarm_pkg::TRIP_RST;
		end else if (wr_evt && sel_crit && !crit_lock_r) begin
			crit_r <= xfer.wdata & temp_alarm_pkg::TRIP_MASK;
		end
	end

	// Read-back waits one cycle so a write in the same request has
	// landed; pointer and data are still held by the link side
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rd_evt_r <= temp_alarm_pkg::FLAG_RST;
		end else begin
			rd_evt_r <= req_evt;
		end
	end

	// Read back after any write in the same request; unmapped reads 0
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rdata_r   <= temp_alarm_pkg::DATA_RST;
			ack_tgl_r <= temp_alarm_pkg::FLAG_RST;
		end else if (rd_evt_r) begin
			ack_tgl_r <= ~ack_tgl_r;
			if (sel_upper) begin
				rdata_r <= upper_r;
			end else if (sel_lower) begin
				rdata_r <= lower_r;
			end else if (sel_crit) begin
				rdata_r <= crit_r;
			end else begin
				rdata_r <= temp_alarm_pkg::DATA_RST;
			end
		end
	end
	assign xfer.ack_tgl = ack_tgl_r;
	assign xfer.rdata   = rdata_r;

	// ==========================================================
	// Comparator
	logic signed [13:0] temp_s, up_s, lo_s, cr_s, hyst_s;
	logic up_hi_r, lo_lo_r, cr_hi_r, alarm_r;
	logic alarm_nxt;

	assign temp_s = {{2{temp_meas[11]}}, temp_meas};
	assign up_s   = thr_ext(upper_r);
	assign lo_s   = thr_ext(lower_r);
	assign cr_s   = thr_ext(crit_r);
	assign hyst_s = hyst_steps(hysteresis_select);

	// Hysteresis only delays clearing on a falling temperature
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			up_hi_r <= temp_alarm_pkg::FLAG_RST;
		end else if (temp_s > up_s) begin
			up_hi_r <= 1'b1;
		end else if (temp_s <= up_s - hyst_s) begin
			up_hi_r <= 1'b0;
		end
	end

	// Lower side: hysteresis is on the setting edge here
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			lo_lo_r <= temp_alarm_pkg::FLAG_RST;
		end else if (temp_s < lo_s - hyst_s) begin
			lo_lo_r <= 1'b1;
		end else if (temp_s >= lo_s) begin
			lo_lo_r <= 1'b0;
		end
	end

	// Critical side
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cr_hi_r <= temp_alarm_pkg::FLAG_RST;
		end else if (temp_s > cr_s) begin
			cr_hi_r <= 1'b1;
		end else if (temp_s <= cr_s - hyst_s) begin
			cr_hi_r <= 1'b0;
		end
	end

	// Output select; registered so the pin never glitches
	always_comb begin
		if (!alarm_output_enable) begin
			alarm_nxt = 1'b0;
		end else if (critical_only) begin
			alarm_nxt = cr_hi_r;
		end else begin
			alarm_nxt = up_hi_r | lo_lo_r | cr_hi_r;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			alarm_r <= temp_alarm_pkg::FLAG_RST;
		end else begin
			alarm_r <= alarm_nxt;
		end
	end

	assign alarm_out       = alarm_r;
	assign upper_alarm     = up_hi_r;
	assign lower_alarm     = lo_lo_r;
	assign crit_alarm      = cr_hi_r;
	assign window_locked   = win_lock_r;
	assign critical_locked = crit_lock_r;

	// ==========================================================
	// Checks
	upper_lock_a: assert property (@(posedge sys_clk) disable iff (rst)
		wr_evt && sel_upper && win_lock_r |=> $stable(upper_r))
		else $error("upper limit written while locked");

	lower_lock_a: assert property (@(posedge sys_clk) disable iff (rst)
		wr_evt && sel_lower && win_lock_r |=> $stable(lower_r))
		else $error("lower limit written while locked");

	crit_lock_a: assert property (@(posedge sys_clk) disable iff (rst)
		wr_evt && sel_crit && crit_lock_r |=> $stable(crit_r))
		else $error("critical limit written while locked");

	upper_write_a: assert property (@(posedge sys_clk) disable iff (rst)
		wr_evt && sel_upper && !win_lock_r |=>
		upper_r == ($past(xfer.wdata) & temp_alarm_pkg::TRIP_MASK))
		else $error("upper limit write not taken");

	lower_write_a: assert property (@(posedge sys_clk) disable iff (rst)
		wr_evt && sel_lower && !win_lock_r |=>
		lower_r == ($past(xfer.wdata) & temp_alarm_pkg::TRIP_MASK))
		else $error("lower limit write not taken");

	crit_write_a: assert property (@(posedge sys_clk) disable iff (rst)
		wr_evt && sel_crit && !crit_lock_r |=>
		crit_r == ($past(xfer.wdata) & temp_alarm_pkg::TRIP_MASK))
		else $error("critical limit write not taken");

	rsvd_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
		((upper_r | lower_r | crit_r) & ~temp_alarm_pkg::TRIP_MASK) == 0)
		else $error("reserved bits not zero");

	upper_trip_a: assert property (@(posedge sys_clk) disable iff (rst)
		temp_s > up_s |=> upper_alarm)
		else $error("upper alarm missed");

	lower_trip_a: assert property (@(posedge sys_clk) disable iff (rst)
		temp_s < lo_s - hyst_s |=> lower_alarm)
		else $error("lower alarm missed");

	crit_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
		cr_hi_r && temp_s > cr_s - hyst_s |=> cr_hi_r)
		else $error("critical alarm released early");

	out_enable_a: assert property (@(posedge sys_clk) disable iff (rst)
		!alarm_output_enable |=> !alarm_out)
		else $error("alarm driven while disabled");

	crit_only_a: assert property (@(posedge sys_clk) disable iff (rst)
		alarm_output_enable && critical_only |=> alarm_out == $past(cr_hi_r))
		else $error("critical-only output wrong");

	lock_sticky_a: assert property (@(posedge sys_clk) disable iff (rst)
		win_lock_r && crit_lock_r |=> win_lock_r [*2] ##0 crit_lock_r)
		else $error("lock bit cleared");

endmodule : temp_alarm_limit_registers

// file: logic/temp_alarm_pkg.sv
// Constants shared by the trip-point register bank and its link port
package temp_alarm_pkg;

	// ==========================================================
	// Register pointers and field layout
	localparam logic [7:0]  PTR_UPPER  = 8'h02;
	localparam logic [7:0]  PTR_LOWER  = 8'h03;
	localparam logic [7:0]  PTR_CRIT   = 8'h04;
	localparam logic [15:0] TRIP_RST   = 16'h0000;
	localparam logic [15:0] TRIP_MASK  = 16'h1FFC;
	localparam int          THR_MSB    = 12;
	localparam int          THR_LSB    = 2;

	// ==========================================================
	// Hysteresis in steps of 0.125 degC
	localparam logic [13:0] HYST_OFF   = 14'h0000;
	localparam logic [13:0] HYST_1P5   = 14'h000C;
	localparam logic [13:0] HYST_3P0   = 14'h0018;
	localparam logic [13:0] HYST_6P0   = 14'h0030;
	localparam logic [1:0]  HSEL_OFF   = 2'h0;
	localparam logic [1:0]  HSEL_1P5   = 2'h1;
	localparam logic [1:0]  HSEL_3P0   = 2'h2;

	// ==========================================================
	// Reset values of status and handshake state
	localparam logic        FLAG_RST   = 1'h0;
	localparam logic [15:0] DATA_RST   = 16'h0000;
	localparam logic [7:0]  PTR_RST    = 8'h00;

endpackage : temp_alarm_pkg

// file: logic/reg_xfer_if.sv
// Toggle handshake carrying register requests between the two clocks
`timescale 1ns/10ps
interface reg_xfer_if;
	logic        req_tgl;  // Flips once per request, link domain
	logic        write;    // Request is a write
	logic [7:0]  ptr;      // Register pointer
	logic [15:0] wdata;    // Write data, held until acknowledged
	logic        ack_tgl;  // Flips once per completion, core domain
	logic [15:0] rdata;    // Read data, held until next request

	modport link (output req_tgl, write, ptr, wdata,
		input ack_tgl, rdata);
	modport core (input req_tgl, write, ptr, wdata,
		output ack_tgl, rdata);
endinterface : reg_xfer_if

// file: logic/link_port.sv
// Link-clock side of the register access path
`timescale 1ns/10ps
module link_port (
	input  wire logic        link_clk,    // Link clock
	input  wire logic        rst,         // Core reset, asynchronous here
	input  wire logic        link_req,    // Request pulse
	input  wire logic        link_write,  // 1 write, 0 read
	input  wire logic [7:0]  link_ptr,    // Register pointer
	input  wire logic [15:0] link_wdata,  // Write data
	output logic             link_busy,   // Request outstanding
	output logic             link_done,   // Completion pulse
	output logic [15:0]      link_rdata,  // Read data
	reg_xfer_if.link         xfer         // Crossing to the core
);

	logic rst_s1_r, rst_s2_r;
	logic ack_s1_r, ack_s2_r, ack_s3_r;
	logic busy_r, done_r, req_tgl_r, write_r;
	logic [7:0]  ptr_r;
	logic [15:0] wdata_r, rdata_r;
	logic ack_evt;

	// ==========================================================
	// Reset brought into the link domain
	always_ff @(posedge link_clk) begin
		rst_s1_r <= rst;
		rst_s2_r <= rst_s1_r;
	end

	// Acknowledge toggle synchroniser; stage one feeds stage two only
	always_ff @(posedge link_clk) begin
		ack_s1_r <= xfer.ack_tgl;
		ack_s2_r <= ack_s1_r;
		ack_s3_r <= ack_s2_r;
	end
	assign ack_evt = ack_s2_r ^ ack_s3_r;

	// Request capture; a request while busy is dropped, so the held
	// pointer and data never change under the core's feet
	always_ff @(posedge link_clk) begin
		if (rst_s2_r) begin
			busy_r    <= temp_alarm_pkg::FLAG_RST;
			req_tgl_r <= temp_alarm_pkg::FLAG_RST;
			write_r   <= temp_alarm_pkg::FLAG_RST;
			ptr_r     <= temp_alarm_pkg::PTR_RST;
			wdata_r   <= temp_alarm_pkg::DATA_RST;
		end else if (link_req && !busy_r) begin
			busy_r    <= 1'b1;
			req_tgl_r <= ~req_tgl_r;
			write_r   <= link_write;
			ptr_r     <= link_ptr;
			wdata_r   <= link_wdata;
		end else if (ack_evt) begin
			busy_r    <= 1'b0;
		end
	end

	// Completion: core read data is stable once the ack is seen
	always_ff @(posedge link_clk) begin
		if (rst_s2_r) begin
			done_r  <= temp_alarm_pkg::FLAG_RST;
			rdata_r <= temp_alarm_pkg::DATA_RST;
		end else begin
			done_r <= ack_evt;
			if (ack_evt) begin
				rdata_r <= xfer.rdata;
			end
		end
	end

	assign xfer.req_tgl = req_tgl_r;
	assign xfer.write   = write_r;
	assign xfer.ptr     = ptr_r;
	assign xfer.wdata   = wdata_r;
	assign link_busy    = busy_r;
	assign link_done    = done_r;
	assign link_rdata   = rdata_r;

endmodule : link_port

// file: sim/link_host.sv
// Host side of the register link: issues one request at a time
`timescale 1ns/10ps
module link_host (
	input  wire logic        link_clk,   // Link clock
	input  wire logic        link_done,  // Completion pulse
	input  wire logic [15:0] link_rdata, // Read data
	output logic             link_req,   // Request pulse
	output logic             link_write, // 1 write, 0 read
	output logic [7:0]       link_ptr,   // Register pointer
	output logic [15:0]      link_wdata  // Write data
);
	initial begin
		link_req = 1'b0;
		link_write = 1'b0;
		link_ptr = 8'h00;
		link_wdata = 16'h0000;
	end

	// ==========================================================
	// One transfer: pulse the request, hold qualifiers until done
	task automatic xfer(input logic w, input logic [7:0] p,
		input logic [15:0] d, output logic [15:0] rd, output logic ok);
		int i;
		@(posedge link_clk);
		link_req <= 1'b1;
		link_write <= w;
		link_ptr <= p;
		link_wdata <= d;
		@(posedge link_clk);
		link_req <= 1'b0;
		ok = 1'b0;
		// Done lasts one link cycle; read data is taken at that edge
		for (i = 0; i < 20; i++) begin
			@(posedge link_clk);
			if (link_done === 1'b1) begin
				ok = 1'b1;
				break;
			end
		end
		rd = link_rdata;
		@(posedge link_clk);
		// Released lines do not keep their value, so flip them
		link_write <= ~w;
		link_ptr <= ~p;
		link_wdata <= ~d;
	endtask : xfer
endmodule : link_host

// file: sim/temp_alarm_limit_registers_test.sv
// Self-checking bench for the trip-point registers and comparator
`timescale 1ns/10ps
module temp_alarm_limit_registers_test;
	logic        sys_clk, rst, link_clk, link_req, link_write;
	logic        link_busy, link_done, ok;
	logic [7:0]  link_ptr;
	logic [15:0] link_wdata, link_rdata, rd, d;
	logic [11:0] temp_meas;
	logic [1:0]  hysteresis_select;
	logic        window_lock_bit, critical_lock_bit;
	logic        alarm_output_enable, critical_only;
	logic        alarm_out, upper_alarm, lower_alarm, crit_alarm;
	logic        window_locked, critical_locked, up_e, lo_e, cr_e;
	logic [15:0] regs [3];
	int          errors, n_tests, seed, i, k;

	temp_alarm_limit_registers DUT (.sys_clk(sys_clk), .rst(rst),
		.link_clk(link_clk), .link_req(link_req), .link_write(link_write),
		.link_ptr(link_ptr), .link_wdata(link_wdata),
		.link_busy(link_busy), .link_done(link_done),
		.link_rdata(link_rdata), .temp_meas(temp_meas),
		.window_lock_bit(window_lock_bit),
		.critical_lock_bit(critical_lock_bit),
		.hysteresis_select(hysteresis_select),
		.alarm_output_enable(alarm_output_enable),
		.critical_only(critical_only), .alarm_out(alarm_out),
		.upper_alarm(upper_alarm), .lower_alarm(lower_alarm),
		.crit_alarm(crit_alarm), .window_locked(window_locked),
		.critical_locked(critical_locked));
	link_host host (.link_clk(link_clk), .link_done(link_done),
		.link_rdata(link_rdata), .link_req(link_req),
		.link_write(link_write), .link_ptr(link_ptr),
		.link_wdata(link_wdata));

	// ==========================================================
	// Clocks: link edges offset so the domains never line up
	initial sys_clk = 1'b0;
	always #2 sys_clk = ~sys_clk;
	initial begin
		link_clk = 1'b0;
		#1.3;
		forever #6 link_clk = ~link_clk;
	end

	// ==========================================================
	// Expectation helpers, all in 0.125 degC steps
	function automatic logic signed [13:0] hv(input logic [1:0] s);
		case (s)
			2'h0: return temp_alarm_pkg::HYST_OFF;
			2'h1: return temp_alarm_pkg::HYST_1P5;
			2'h2: return temp_alarm_pkg::HYST_3P0;
			default: return temp_alarm_pkg::HYST_6P0;
		endcase
	endfunction : hv
	function automatic logic signed [13:0] th(input logic [15:0] r);
		return {{2{r[12]}}, r[12:1]};
	endfunction : th
	function automatic logic nx_hi(input logic p,
		input logic signed [13:0] t, lim, h);
		if (t > lim) return 1'b1;
		if (t <= lim - h) return 1'b0;
		return p;
	endfunction : nx_hi
	function automatic logic nx_lo(input logic p,
		input logic signed [13:0] t, lim, h);
		if (t < lim - h) return 1'b1;
		if (t >= lim) return 1'b0;
		return p;
	endfunction : nx_lo

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic complete_run();
		if (errors == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : complete_run

	// Register access; a missing completion ends the run
	task automatic rw(input logic w, input logic [7:0] p,
		input logic [15:0] dv);
		host.xfer(w, p, dv, rd, ok);
		if (ok !== 1'b1) begin
			errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, ok, 1'b1);
			complete_run();
		end
		chk({15'h0, link_busy}, 16'h0000);
	endtask : rw

	// Apply one temperature and setting, let it settle, compare
	task automatic settle(input int tv, input logic [1:0] hs,
		input logic en, input logic co);
		logic signed [13:0] ts;
		ts = tv[13:0];
		@(posedge sys_clk);
		temp_meas <= tv[11:0];
		hysteresis_select <= hs;
		alarm_output_enable <= en;
		critical_only <= co;
		repeat (3) @(posedge sys_clk);
		#1;
		up_e = nx_hi(up_e, ts, th(regs[0]), hv(hs));
		lo_e = nx_lo(lo_e, ts, th(regs[1]), hv(hs));
		cr_e = nx_hi(cr_e, ts, th(regs[2]), hv(hs));
		chk({15'h0, upper_alarm}, {15'h0, up_e});
		chk({15'h0, lower_alarm}, {15'h0, lo_e});
		chk({15'h0, crit_alarm}, {15'h0, cr_e});
		chk({15'h0, alarm_out},
			{15'h0, en & (co ? cr_e : (up_e | lo_e | cr_e))});
	endtask : settle

	// ==========================================================
	// Main sequence
	initial begin
		seed = 76668;
		errors = 0;
		n_tests = 0;
		rst = 1'b1;
		temp_meas = 12'h000;
		hysteresis_select = 2'h0;
		window_lock_bit = 1'b0;
		critical_lock_bit = 1'b0;
		alarm_output_enable = 1'b0;
		critical_only = 1'b0;
		{up_e, lo_e, cr_e} = 3'h0;
		// Held long enough for the link side to see it too
		repeat (16) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (8) @(posedge link_clk);
		chk({8'h0, link_busy, link_done, alarm_out, upper_alarm,
			lower_alarm, crit_alarm, window_locked, critical_locked},
			16'h0000);
		for (k = 0; k < 3; k++) begin
			rw(1'b0, 8'h02 + 8'(k), 16'h0000);
			chk(rd, temp_alarm_pkg::TRIP_RST);
		end
		// Full-ones first to hit every reserved bit, then random words
		for (i = 0; i < 12; i++) begin
			k = i % 3;
			d = (i < 3) ? 16'hFFFF : 16'($random(seed));
			rw(1'b1, 8'h02 + 8'(k), d);
			chk(rd, d & 16'h1FFC);
			rw(1'b0, 8'h02 + 8'(k), ~d);
			chk(rd, d & 16'h1FFC);
		end
		rw(1'b0, 8'h05, 16'h0000);
		chk(rd, 16'h0000);
		// Limits 5 degC, -2 degC and 9 degC
		regs = '{16'h0050, 16'h1FE0, 16'h0090};
		for (k = 0; k < 3; k++) begin
			rw(1'b1, 8'h02 + 8'(k), regs[k]);
		end
		// Zero hysteresis leaves no band, so the model starts in step
		settle(0, 2'h0, 1'b1, 1'b0);
		for (i = 0; i < 400; i++) begin
			settle(-70 + int'({$random(seed)} % 201), 2'($random(seed)),
				(($random(seed) & 3) != 0), 1'($random(seed)));
		end
		// Window lock: pulse the request, then try to rewrite
		@(posedge sys_clk);
		window_lock_bit <= 1'b1;
		@(posedge sys_clk);
		window_lock_bit <= 1'b0;
		repeat (3) @(posedge sys_clk);
		#1;
		chk({14'h0, window_locked, critical_locked}, 16'h0002);
		for (k = 0; k < 3; k++) begin
			rw(1'b1, 8'h02 + 8'(k), 16'h0AA8);
			rw(1'b0, 8'h02 + 8'(k), 16'h0000);
			chk(rd, (k == 2) ? 16'h0AA8 : regs[k]);
		end
		@(posedge sys_clk);
		critical_lock_bit <= 1'b1;
		@(posedge sys_clk);
		critical_lock_bit <= 1'b0;
		repeat (3) @(posedge sys_clk);
		#1;
		chk({14'h0, window_locked, critical_locked}, 16'h0003);
		rw(1'b1, 8'h04, 16'h1554);
		rw(1'b0, 8'h04, 16'h0000);
		chk(rd, 16'h0AA8);
		complete_run();
	end
endmodule : temp_alarm_limit_registers_test
